// *** logic/clock_manager_params.svh ***
// Register offsets, field positions, reset values and masks of the clock manager.
// How it works
// - Duty at most half: coarse*25% plus low fine.
// - Duty above half: use middle fine field instead.
// - Coarse field picks one quarter-period duty range.
// - Mode bit 0: delay-locked or phase-locked, default delay.
// - Mode bit 2: feedback source, phase-locked only.
// - Mode bit 4: 1x or 2x, delay-locked only.
// - Fast I/O clock source field, four sources.
// - System clock source field, code 11 reserved.
// - Control bit 0 switches analog supply.
// - Control bit 1 resets all manager logic.
// - Control bit 2 resets only delay-locked generation.
// - Configuration hold: supply off, bus off, lock low.
// - Bit 6 lets manager run during configuration.
// - Control bit 7 shields manager from global reset.
// - Phase adjustment only in delay-locked mode.
// - Phase is delay times 11.25, wrapped above 16.
// - Divider: zero bypasses, above eight wraps modulo eight.
`ifndef CLOCK_MANAGER_PARAMS_SVH
`define CLOCK_MANAGER_PARAMS_SVH

// Register offsets on the plain register port.
`define CM_ADDR_IN_DIV   4'h0
`define CM_ADDR_OUT_DIV  4'h2
`define CM_ADDR_DUTY     4'h4
`define CM_ADDR_MODE     4'h5
`define CM_ADDR_SRC      4'h6
`define CM_ADDR_CTRL     4'h7

// Writable bit masks; reserved bits are cleared by these.
`define CM_MASK_DIV      8'h8F
`define CM_MASK_DUTY     8'hFF
`define CM_MASK_MODE     8'h15
`define CM_MASK_SRC      8'hF0
`define CM_MASK_CTRL     8'hC7

// Reset values.
`define CM_RST_DIV       8'h00
`define CM_RST_DUTY      8'h00
`define CM_RST_MODE      8'h00
`define CM_RST_SRC       8'h00
`define CM_RST_CTRL      8'h01

// Field positions.
`define CM_BIT_PLL       0
`define CM_BIT_FB        2
`define CM_BIT_DOUBLE    4
`define CM_BIT_PWR       0
`define CM_BIT_MGR_RST   1
`define CM_BIT_DLL_RST   2
`define CM_BIT_CFG_RUN   6
`define CM_BIT_GSR_OFF   7
`define CM_BIT_DIV_RST   7

// Phase arithmetic in quarter degrees: 11.25 deg step, 360 deg turn.
`define CM_PHASE_STEP_Q  12'h02D
`define CM_PHASE_TURN_Q  12'h5A0
`define CM_PHASE_MID     6'h10

`endif

// *** logic/clock_manager_pkg.sv ***
// Types shared by the clock manager control logic and its bench.
`default_nettype none
package clock_manager_pkg;

	// One register port request, sampled on the rising clock edge.
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	// One setup word from the configuration bitstream.
	typedef struct packed {
		logic       valid;
		logic [3:0] addr;
		logic [7:0] data;
	} cfg_load_t;

	// Clock source selection for either output multiplexer.
	typedef enum logic [1:0] {
		SRC_BYPASS,
		SRC_DLL,
		SRC_TAPPED,
		SRC_DIVIDED
	} src_sel_t;

	// Steering of the loop and the output multiplexers.
	typedef struct packed {
		logic     loop_pll;
		logic     fb_delay_line;
		logic     double_out;
		src_sel_t fast_io_clock_src;
		src_sel_t sys_clock_src;
	} loop_ctrl_t;

	// Operating states of the manager.
	typedef enum logic [1:0] {
		ST_CFG_HOLD,
		ST_POWER_OFF,
		ST_RESET,
		ST_RUN
	} mgr_state_t;

endpackage
`default_nettype wire

// *** logic/clock_manager_control_regs.sv ***
// Control registers and steering logic of the programmable clock manager.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "clock_manager_params.svh"
module clock_manager_control_regs
	import clock_manager_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              arst_n,
	input  wire reg_req_t          reg_req,
	output var  logic [7:0]        rd_data,
	input  wire cfg_load_t         cfg_load,
	input  wire logic              config_done,
	input  wire logic              global_set_reset_n,
	input  wire logic              loop_locked_in,
	output var  loop_ctrl_t        loop_ctrl,
	output var  logic [5:0]        duty_delay_32nds,
	output var  logic signed [11:0] phase_quarter_deg,
	output var  logic              analog_power_on,
	output var  logic              manager_reset,
	output var  logic              dll_reset,
	output var  logic              lock_out,
	output var  logic              out_bus_oe_n,
	output var  logic              input_div_tick,
	output var  logic              output_div_tick
);

	// Effective divide ratio of a four-bit divider field, 1 to 8.
	// Zero means bypass, which ticks every cycle like a ratio of one.
	function automatic logic [3:0] div_ratio(input logic [3:0] code);
		logic [3:0] r;
		r = code;
		// Divider wrap rule.
		// modulo eight wrap
		if (code == 4'h0) begin
			r = 4'h1;
		end else if (code > 4'h8) begin
			r = {1'b0, code[2:0]};
		end
		return r;
	endfunction

	// Masked register update; reserved bits never store anything.
	function automatic logic [7:0] masked(input logic [7:0] d,
		input logic [7:0] m);
		return d & m;
	endfunction

	// Stored registers.
	logic [7:0] in_div_reg;         // Input divider control.
	logic [7:0] out_div_reg;        // Output divider control.
	logic [7:0] one_x_duty_delay_reg;
	logic [7:0] loop_mode_select_reg;
	logic [7:0] output_source_select_reg;
	logic [7:0] manager_power_reset_ctrl_reg;

	// Manager state machine.
	mgr_state_t state_reg;
	mgr_state_t state_next;

	// Divider counters.
	logic [2:0] in_cnt_reg;
	logic [2:0] out_cnt_reg;

	// Output flip-flops.
	logic [7:0]        rd_data_reg;
	loop_ctrl_t        loop_ctrl_reg;
	logic [5:0]        duty_reg;
	logic signed [11:0] phase_reg;
	logic              power_reg;
	logic              mgr_rst_reg;
	logic              dll_rst_reg;
	logic              lock_reg;
	logic              oe_n_reg;
	logic              in_tick_reg;
	logic              out_tick_reg;

	// Write decoding; the register port wins over a bitstream word
	// landing in the same cycle, since software is the later authority.
	wire        sw_wr = reg_req.wr;
	wire        bs_wr = cfg_load.valid & ~config_done & ~sw_wr;
	wire        any_wr = sw_wr | bs_wr;
	wire [3:0]  wr_addr = sw_wr ? reg_req.addr : cfg_load.addr;
	wire [7:0]  wr_data = sw_wr ? reg_req.wdata : cfg_load.data;
	// One strobe per mapped offset; others drop.
	wire        wr_in_div = any_wr & (wr_addr == `CM_ADDR_IN_DIV);
	wire        wr_out_div = any_wr & (wr_addr == `CM_ADDR_OUT_DIV);
	wire        wr_duty = any_wr & (wr_addr == `CM_ADDR_DUTY);
	wire        wr_mode = any_wr & (wr_addr == `CM_ADDR_MODE);
	wire        wr_src = any_wr & (wr_addr == `CM_ADDR_SRC);
	wire        wr_ctrl = any_wr & (wr_addr == `CM_ADDR_CTRL);

	// Control bits by name.
	// They act from the stored value, after the write edge.
	wire ctrl_pwr = manager_power_reset_ctrl_reg[`CM_BIT_PWR];
	wire ctrl_mgr_rst = manager_power_reset_ctrl_reg[`CM_BIT_MGR_RST];
	wire ctrl_dll_rst = manager_power_reset_ctrl_reg[`CM_BIT_DLL_RST];
	wire ctrl_cfg_run = manager_power_reset_ctrl_reg[`CM_BIT_CFG_RUN];
	wire ctrl_gsr_off = manager_power_reset_ctrl_reg[`CM_BIT_GSR_OFF];

	// Chip-wide reset reaches the manager only while not shielded.
	// global reset gate
	wire gsr_hit = ~global_set_reset_n & ~ctrl_gsr_off;

	// Configuration hold: no running before done unless allowed.
	// configuration hold
	wire cfg_hold = ~config_done & ~ctrl_cfg_run;

	// Read selection; unmapped offsets answer zero.
	// Reserved bits read zero as they are never stored.
	wire [7:0] rd_mux =
		(reg_req.addr == `CM_ADDR_IN_DIV)  ? in_div_reg :
		(reg_req.addr == `CM_ADDR_OUT_DIV) ? out_div_reg :
		(reg_req.addr == `CM_ADDR_DUTY)    ? one_x_duty_delay_reg :
		(reg_req.addr == `CM_ADDR_MODE)    ? loop_mode_select_reg :
		(reg_req.addr == `CM_ADDR_SRC)     ? output_source_select_reg :
		(reg_req.addr == `CM_ADDR_CTRL)    ?
			manager_power_reset_ctrl_reg : 8'h00;

	// Loop steering decode.
	// loop type select
	wire is_pll = loop_mode_select_reg[`CM_BIT_PLL];
	wire fb_sel = is_pll & loop_mode_select_reg[`CM_BIT_FB];
	wire dbl_sel = ~is_pll & loop_mode_select_reg[`CM_BIT_DOUBLE];
	wire [1:0] fio_code = output_source_select_reg[5:4];
	wire [1:0] sys_code = output_source_select_reg[7:6];
	// reserved code falls back to bypass
	wire [1:0] sys_eff = (sys_code == 2'h3) ? 2'h0 : sys_code;

	// Duty and delay decode in 32nds of a period.
	// coarse range select
	wire [1:0] coarse = one_x_duty_delay_reg[7:6];
	// low fine field at or below half
	wire [2:0] fine = coarse[1] ? one_x_duty_delay_reg[5:3] :
		one_x_duty_delay_reg[2:0];
	wire [5:0] duty_32 = {1'b0, coarse, 3'h0} + {3'h0, fine} + 6'h01;

	// Phase in quarter degrees from the delay in 32nds.
	// Quarter degrees keep the 11.25 degree step whole.
	// phase from delay
	wire [11:0] phase_raw = {6'h00, duty_32} * `CM_PHASE_STEP_Q;
	// A delay of exactly half a period keeps its sign.
	wire [11:0] phase_wrap = (duty_32 > `CM_PHASE_MID) ?
		phase_raw - `CM_PHASE_TURN_Q : phase_raw;
	wire [11:0] phase_sel = is_pll ? 12'h000 : phase_wrap;

	// Divider ratios and wrap points.
	// A zero ratio field still ticks every cycle.
	wire [3:0] in_ratio = div_ratio(in_div_reg[3:0]);
	wire [3:0] out_ratio = div_ratio(out_div_reg[3:0]);
	wire [2:0] in_last = 3'(in_ratio - 4'h1);
	wire [2:0] out_last = 3'(out_ratio - 4'h1);
	// A manager reset also holds both dividers quiet.
	wire in_div_held = in_div_reg[`CM_BIT_DIV_RST] | mgr_rst_reg;
	wire out_div_held = out_div_reg[`CM_BIT_DIV_RST] | mgr_rst_reg;
	// A count already past a lower ratio written mid-count wraps at
	// once, so the new rate starts without a long silent stretch.
	wire in_wrap = (in_cnt_reg >= in_last);
	wire out_wrap = (out_cnt_reg >= out_last);

	// State transitions. Hold outranks power, power outranks reset,
	// and reaching run from any other state passes through one reset cycle so
	// the loop always restarts from a known point.
	always_comb begin
		state_next = state_reg;
		// Every state code is used; no default.
		unique case (state_reg)
			ST_CFG_HOLD: begin
				// Waits for done or the run bit.
				if (!cfg_hold) begin
					state_next = ST_RESET;
				end
			end
			ST_POWER_OFF: begin
				// Supply off until switched on.
				if (cfg_hold) begin
					state_next = ST_CFG_HOLD;
				end else if (ctrl_pwr) begin
					state_next = ST_RESET;
				end
			end
			ST_RESET: begin
				// Stays while reset is asked for.
				if (cfg_hold) begin
					state_next = ST_CFG_HOLD;
				end else if (!ctrl_pwr) begin
					state_next = ST_POWER_OFF;
				end else if (!ctrl_mgr_rst && !gsr_hit) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				// Any hold or reset leaves here.
				if (cfg_hold) begin
					state_next = ST_CFG_HOLD;
				end else if (!ctrl_pwr) begin
					state_next = ST_POWER_OFF;
				end else if (ctrl_mgr_rst || gsr_hit) begin
					state_next = ST_RESET;
				end
			end
		endcase
	end

	// State register.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			// Reset waits on configuration first.
			state_reg <= ST_CFG_HOLD;
		end else begin
			state_reg <= state_next;
		end
	end

	// Divider and duty registers, cleared by an unshielded chip reset.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			in_div_reg <= `CM_RST_DIV;
			out_div_reg <= `CM_RST_DIV;
			one_x_duty_delay_reg <= `CM_RST_DUTY;
		end else if (gsr_hit) begin
			in_div_reg <= `CM_RST_DIV;
			out_div_reg <= `CM_RST_DIV;
			one_x_duty_delay_reg <= `CM_RST_DUTY;
		end else begin
			// Each register takes only its own offset.
			if (wr_in_div) begin
				in_div_reg <= masked(wr_data, `CM_MASK_DIV);
			end
			if (wr_out_div) begin
				out_div_reg <= masked(wr_data, `CM_MASK_DIV);
			end
			if (wr_duty) begin
				one_x_duty_delay_reg <= masked(wr_data, `CM_MASK_DUTY);
			end
		end
	end

	// Mode, source and control registers. The control register returns
	// to its reset value too, which leaves its shield bit at zero as it was.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			loop_mode_select_reg <= `CM_RST_MODE;
			output_source_select_reg <= `CM_RST_SRC;
			manager_power_reset_ctrl_reg <= `CM_RST_CTRL;
		end else if (gsr_hit) begin
			loop_mode_select_reg <= `CM_RST_MODE;
			output_source_select_reg <= `CM_RST_SRC;
			manager_power_reset_ctrl_reg <= `CM_RST_CTRL;
		end else begin
			// Bitstream words arrive by this path too.
			if (wr_mode) begin
				loop_mode_select_reg <= masked(wr_data, `CM_MASK_MODE);
			end
			if (wr_src) begin
				output_source_select_reg <= masked(wr_data, `CM_MASK_SRC);
			end
			// Supply and reset bits act one edge later.
			if (wr_ctrl) begin
				manager_power_reset_ctrl_reg <=
					masked(wr_data, `CM_MASK_CTRL);
			end
		end
	end

	// Input divider counter; held at zero while its reset bit is set.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			in_cnt_reg <= 3'h0;
			in_tick_reg <= 1'b0;
		end else if (in_div_held) begin
			in_cnt_reg <= 3'h0;
			in_tick_reg <= 1'b0;
		end else begin
			// The tick stands in the cycle after a wrap.
			in_cnt_reg <= in_wrap ? 3'h0 : in_cnt_reg + 3'h1;
			in_tick_reg <= in_wrap;
		end
	end

	// Output divider counter; same shape as the input one.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_cnt_reg <= 3'h0;
			out_tick_reg <= 1'b0;
		end else if (out_div_held) begin
			out_cnt_reg <= 3'h0;
			out_tick_reg <= 1'b0;
		end else begin
			// Same timing as the input divider.
			out_cnt_reg <= out_wrap ? 3'h0 : out_cnt_reg + 3'h1;
			out_tick_reg <= out_wrap;
		end
	end

	// Read data stands for exactly the cycle after the strobe.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data_reg <= 8'h00;
		end else begin
			// Zero between reads keeps stale data off.
			rd_data_reg <= reg_req.rd ? rd_mux : 8'h00;
		end
	end

	// Steering and decode outputs, one cycle behind the registers.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			loop_ctrl_reg <= '0;
			// Duty field zero decodes to one 32nd.
			duty_reg <= 6'h01;
			phase_reg <= 12'sh000;
		end else begin
			// Loop type, feedback, doubling, sources.
			loop_ctrl_reg <= '{loop_pll: is_pll,
				fb_delay_line: fb_sel,
				double_out: dbl_sel,
				fast_io_clock_src: src_sel_t'(fio_code),
				sys_clock_src: src_sel_t'(sys_eff)};
			duty_reg <= duty_32;
			phase_reg <= signed'(phase_sel);
		end
	end

	// Power, reset, lock and bus enable from the manager state.
	// Lock is only reported once the loop runs and, in delay-locked mode,
	// the generator is not held, so a reset never shows a stale lock.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			// Supply off and everything held in reset.
			power_reg <= 1'b0;
			mgr_rst_reg <= 1'b1;
			dll_rst_reg <= 1'b1;
			lock_reg <= 1'b0;
			oe_n_reg <= 1'b1;
		end else begin
			// supply off and bus released in hold
			power_reg <= (state_next == ST_RESET) |
				(state_next == ST_RUN);
			oe_n_reg <= (state_next == ST_CFG_HOLD);
			mgr_rst_reg <= (state_next != ST_RUN);
			dll_rst_reg <= (state_next != ST_RUN) | ctrl_dll_rst;
			lock_reg <= (state_next == ST_RUN) & loop_locked_in &
				~(ctrl_dll_rst & ~is_pll);
		end
	end

	// Every output straight from its flip-flop.
	// No gate follows any of these flip-flops.
	assign rd_data = rd_data_reg;
	assign loop_ctrl = loop_ctrl_reg;
	assign duty_delay_32nds = duty_reg;
	assign phase_quarter_deg = phase_reg;
	assign analog_power_on = power_reg;
	assign manager_reset = mgr_rst_reg;
	assign dll_reset = dll_rst_reg;
	assign lock_out = lock_reg;
	assign out_bus_oe_n = oe_n_reg;
	assign input_div_tick = in_tick_reg;
	assign output_div_tick = out_tick_reg;

endmodule
`default_nettype wire

// *** tb/clock_manager_control_regs_assertions.sv ***
// Checker for the clock manager control register outputs.
`timescale 1ns/1ps
`default_nettype none
module clock_manager_control_regs_checker
	import clock_manager_pkg::*;
(
	input wire logic               core_clk,
	input wire logic               arst_n,
	input wire reg_req_t           reg_req,
	input wire logic [7:0]         rd_data,
	input wire logic               global_set_reset_n,
	input wire loop_ctrl_t         loop_ctrl,
	input wire logic [5:0]         duty_delay_32nds,
	input wire logic signed [11:0] phase_quarter_deg,
	input wire logic               analog_power_on,
	input wire logic               manager_reset,
	input wire logic               lock_out,
	input wire logic               out_bus_oe_n,
	input wire logic               input_div_tick,
	input wire logic               output_div_tick
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	// Write strobes to the duty, mode, source and control registers.
	wire logic wr4 = reg_req.wr && reg_req.addr == 4'h4;
	wire logic wr5 = reg_req.wr && reg_req.addr == 4'h5;
	wire logic wr6 = reg_req.wr && reg_req.addr == 4'h6;
	wire logic wr7 = reg_req.wr && reg_req.addr == 4'h7;
	// Phase expected from the delay, wrapped above half a turn.
	wire logic [11:0] ph_exp = (duty_delay_32nds <= 6'h10) ?
		12'(duty_delay_32nds * 12'h02D) :
		12'(duty_delay_32nds * 12'h02D - 12'h5A0);

	// Duty in 32nds from a written duty byte.
	function automatic logic [5:0] dty(input logic [7:0] w);
		return 6'({w[7:6], 3'h0}) + 6'(w[7] ? w[5:3] : w[2:0]) + 6'h01;
	endfunction

	// Source pair; the reserved system code falls back to bypass.
	function automatic logic [3:0] srcx(input logic [7:0] w);
		return {w[5:4], (w[7:6] == 2'h3) ? 2'h0 : w[7:6]};
	endfunction

	a_duty_decode: assert property (
		wr4 |-> ##2 duty_delay_32nds == dty($past(reg_req.wdata, 2)))
		else $error("duty output does not match written byte");
	a_phase_calc: assert property (
		$past(arst_n) && !loop_ctrl.loop_pll |-> phase_quarter_deg == ph_exp)
		else $error("phase does not follow delay setting");
	a_phase_pll: assert property (
		loop_ctrl.loop_pll |-> phase_quarter_deg == 12'h000)
		else $error("phase nonzero in phase-locked mode");
	a_mode_pll: assert property (
		wr5 |-> ##2 loop_ctrl.loop_pll == $past(reg_req.wdata[0], 2))
		else $error("loop type does not follow mode bit");
	a_src_route: assert property (
		wr6 |-> ##2 4'(loop_ctrl) == srcx($past(reg_req.wdata, 2)))
		else $error("clock sources do not follow selector");
	a_sys_rsvd: assert property (
		loop_ctrl.sys_clock_src != SRC_DIVIDED)
		else $error("reserved system source driven");
	a_power_off: assert property (
		wr7 && !reg_req.wdata[0] && global_set_reset_n
		##1 global_set_reset_n |=> !analog_power_on)
		else $error("supply stays on after switch off");
	a_hold_quiet: assert property (
		out_bus_oe_n |-> !analog_power_on && !lock_out)
		else $error("bus off but supply or lock active");
	a_unmapped_rd: assert property (
		reg_req.rd && (reg_req.addr[3] || reg_req.addr inside {4'h1, 4'h3})
		|=> rd_data == 8'h00)
		else $error("unmapped read returned data");
	a_mgr_quiet: assert property (
		manager_reset && $past(manager_reset)
		|-> !input_div_tick && !output_div_tick && !lock_out)
		else $error("activity while manager held in reset");

	// Main scenarios reached.
	c_pll_on: cover property (wr5 ##2 loop_ctrl.loop_pll);
	c_bus_on: cover property ($fell(out_bus_oe_n));
	c_mgr_rst: cover property ($rose(manager_reset));
endmodule

bind clock_manager_control_regs clock_manager_control_regs_checker i_chk (
	.core_clk, .arst_n, .reg_req, .rd_data, .global_set_reset_n,
	.loop_ctrl, .duty_delay_32nds, .phase_quarter_deg, .analog_power_on,
	.manager_reset, .lock_out, .out_bus_oe_n, .input_div_tick,
	.output_div_tick
);
`default_nettype wire

// *** tb/clock_manager_far_side.sv ***
// Model of configuration logic, chip reset and the analog loop.
`timescale 1ns/1ps
`default_nettype none
module clock_manager_far_side #(
	parameter logic [3:0] LOCK_CYC = 4'h5
) (
	input  wire logic core_clk,
	input  wire logic done_cmd,
	input  wire logic gsr_cmd,
	input  wire logic analog_power_on,
	input  wire logic dll_reset,
	input  wire logic manager_reset,
	output var  logic config_done,
	output var  logic global_set_reset_n,
	output var  logic loop_locked_in
);
	logic [3:0] lock_cnt = 4'h0; // Cycles since the loop could lock.

	// Configuration and chip reset come straight from the bench.
	assign config_done        = done_cmd;
	assign global_set_reset_n = gsr_cmd;
	// A larger LOCK_CYC models a slow loop.
	assign loop_locked_in     = lock_cnt == LOCK_CYC;

	// The loop loses lock whenever power or its reset drops it.
	always @(posedge core_clk) begin
		if (!analog_power_on || dll_reset || manager_reset) begin
			lock_cnt <= 4'h0;
		end else if (lock_cnt != LOCK_CYC) begin
			lock_cnt <= lock_cnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

// *** tb/clock_manager_control_regs_bench.sv ***
// Self-checking bench of the clock manager control registers.
`timescale 1ns/1ps
`default_nettype none
module clock_manager_control_regs_bench
	import clock_manager_pkg::*;
;
	logic               core_clk = 1'b0; // Core clock.
	logic               arst_n = 1'b0;   // Reset, low active.
	reg_req_t           reg_req = '0;    // Register port.
	cfg_load_t          cfg_load = '0;   // Bitstream word.
	logic               done_cmd = 1'b0; // Configuration done.
	logic               gsr_cmd = 1'b1;  // Chip reset, low active.
	wire logic          config_done, global_set_reset_n, loop_locked_in;
	logic [7:0]         rd_data;
	loop_ctrl_t         loop_ctrl;
	logic [5:0]         duty_delay_32nds;
	logic signed [11:0] phase_quarter_deg;
	logic               analog_power_on, manager_reset, dll_reset;
	logic               lock_out, out_bus_oe_n;
	logic               input_div_tick, output_div_tick;
	int                 err_count = 0, n_compared = 0, cyc = 0;

	clock_manager_control_regs i_dut (
		.core_clk, .arst_n, .reg_req, .rd_data, .cfg_load, .config_done,
		.global_set_reset_n, .loop_locked_in, .loop_ctrl,
		.duty_delay_32nds, .phase_quarter_deg, .analog_power_on,
		.manager_reset, .dll_reset, .lock_out, .out_bus_oe_n,
		.input_div_tick, .output_div_tick
	);
	clock_manager_far_side i_far (
		.core_clk, .done_cmd, .gsr_cmd, .analog_power_on, .dll_reset,
		.manager_reset, .config_done, .global_set_reset_n, .loop_locked_in
	);

	// 50 ns clock period.
	initial forever #25 core_clk = ~core_clk;

	// Hang guard; the run needs well under a thousand cycles.
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			final_report;
		end
	end

	// Compares one value and counts it.
	task automatic chk(input string nm, input logic [11:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Reset held for two edges, released on an edge.
	task automatic do_reset;
		@(posedge core_clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
	endtask

	// One-cycle register write.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_req <= '{a, d, 1'b1, 1'b0};
		@(posedge core_clk);
		reg_req <= '0;
	endtask

	// One-cycle read; data stands only in the following cycle.
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk);
		reg_req <= '0;
		@(negedge core_clk);
		chk("rd_data", 12'(rd_data), 12'(e));
	endtask

	// Decoded outputs lag a write by one more edge.
	task automatic look;
		repeat (2) @(negedge core_clk);
	endtask

	// Bounded wait for a level.
	task automatic hold_for(ref logic s, input logic v);
		for (int i = 0; i < 16 && s !== v; i++) @(negedge core_clk);
	endtask

	// One-cycle chip reset pulse.
	task automatic pulse_gsr;
		@(posedge core_clk);
		gsr_cmd <= 1'b0;
		@(posedge core_clk);
		gsr_cmd <= 1'b1;
		repeat (2) @(posedge core_clk);
	endtask

	// Reset values, writable masks and an unmapped hole.
	task automatic t_regs;
		logic [3:0] a [6] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7};
		logic [7:0] m [6] = '{8'h8F, 8'h8F, 8'hFF, 8'h15, 8'hF0, 8'hC7};
		foreach (a[i]) rchk(a[i], (i == 5) ? 8'h01 : 8'h00);
		foreach (a[i]) begin
			wr(a[i], 8'hFF);
			rchk(a[i], m[i]);
		end
		wr(4'h3, 8'hFF);
		rchk(4'h3, 8'h00);
		$display("end t_regs");
	endtask

	// Duty bytes across all four coarse ranges.
	task automatic t_duty;
		logic [7:0]  v [6] = '{8'h00, 8'h64, 8'h47, 8'h88, 8'hF0, 8'hC7};
		logic [11:0] d [6] = '{12'h001, 12'h00D, 12'h010,
			12'h012, 12'h01F, 12'h019};
		logic [11:0] p [6] = '{12'h02D, 12'h249, 12'h2D0,
			12'hD8A, 12'hFD3, 12'hEC5};
		foreach (v[i]) begin
			wr(4'h4, v[i]);
			look;
			chk("duty", 12'(duty_delay_32nds), d[i]);
			chk("phase", phase_quarter_deg, p[i]);
		end
		$display("end t_duty");
	endtask

	// Loop mode bits and every source code.
	task automatic t_mode;
		logic [1:0] s;
		wr(4'h5, 8'h15);
		look;
		chk("loop_ctrl", 12'(loop_ctrl), 12'h060);
		chk("phase", phase_quarter_deg, 12'h000);
		wr(4'h5, 8'h14);
		for (int i = 0; i < 4; i++) begin
			s = 2'(i);
			wr(4'h6, {s, s, 4'h0});
			look;
			chk("loop_ctrl", 12'(loop_ctrl),
				12'({3'h1, s, (s == 2'h3) ? 2'h0 : s}));
		end
		$display("end t_mode");
	endtask

	// Configuration hold, supply switch, running during configuration.
	task automatic t_power;
		look;
		chk("oe_n", 12'(out_bus_oe_n), 12'h001);
		chk("power", 12'(analog_power_on), 12'h000);
		@(posedge core_clk);
		done_cmd <= 1'b1;
		hold_for(analog_power_on, 1'b1);
		chk("power", 12'(analog_power_on), 12'h001);
		hold_for(lock_out, 1'b1);
		chk("lock", 12'(lock_out), 12'h001);
		wr(4'h7, 8'h00);
		look;
		chk("power", 12'(analog_power_on), 12'h000);
		wr(4'h7, 8'h01);
		@(posedge core_clk);
		done_cmd <= 1'b0;
		look;
		chk("oe_n", 12'(out_bus_oe_n), 12'h001);
		wr(4'h7, 8'h41);
		hold_for(out_bus_oe_n, 1'b0);
		chk("power", 12'(analog_power_on), 12'h001);
		$display("end t_power");
	endtask

	// Whole-manager reset, then generator-only reset.
	task automatic t_rst;
		wr(4'h7, 8'h43);
		look;
		chk("mgr_rst", 12'(manager_reset), 12'h001);
		wr(4'h7, 8'h45);
		hold_for(manager_reset, 1'b0);
		look;
		chk("dll_rst", 12'(dll_reset), 12'h001);
		chk("lock", 12'(lock_out), 12'h000);
		rchk(4'h6, 8'hF0);
		wr(4'h7, 8'h41);
		$display("end t_rst");
	endtask

	// Chip reset shielded, then acting normally.
	task automatic t_gsr;
		wr(4'h5, 8'h01);
		wr(4'h7, 8'hC1);
		pulse_gsr;
		rchk(4'h5, 8'h01);
		wr(4'h7, 8'h41);
		pulse_gsr;
		rchk(4'h5, 8'h00);
		rchk(4'h7, 8'h01);
		$display("end t_gsr");
	endtask

	// Divider ratios, wrap codes and the hold bit.
	task automatic t_div;
		logic [3:0]  a [6] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h2};
		logic [7:0]  v [6] = '{8'h03, 8'h09, 8'h00, 8'h83, 8'h0A, 8'h08};
		logic [11:0] e [6] = '{12'h008, 12'h018, 12'h018,
			12'h000, 12'h00C, 12'h003};
		int n;
		@(posedge core_clk);
		done_cmd <= 1'b1;
		foreach (v[i]) begin
			wr(a[i], v[i]);
			repeat (6) @(negedge core_clk);
			n = 0;
			repeat (24) begin
				@(negedge core_clk);
				n += (a[i] == 4'h0) ? input_div_tick : output_div_tick;
			end
			chk("ticks", 12'(n), e[i]);
		end
		$display("end t_div");
	endtask

	// Bitstream setup, and a word dropped by a colliding write.
	task automatic t_cfg;
		@(posedge core_clk);
		done_cmd <= 1'b0;
		@(posedge core_clk);
		cfg_load <= '{1'b1, 4'h5, 8'h11};
		@(posedge core_clk);
		cfg_load <= '{1'b1, 4'h4, 8'hAA};
		reg_req <= '{4'h6, 8'h40, 1'b1, 1'b0};
		@(posedge core_clk);
		cfg_load <= '0;
		reg_req <= '0;
		rchk(4'h5, 8'h11);
		rchk(4'h4, 8'h00);
		rchk(4'h6, 8'h40);
		$display("end t_cfg");
	endtask

	// Counts, verdict and end of run.
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Main sequence; a second reset lands mid-run.
	initial begin
		do_reset;
		t_regs;
		do_reset;
		t_duty;
		t_mode;
		t_power;
		t_rst;
		t_gsr;
		t_div;
		t_cfg;
		final_report;
	end
endmodule
`default_nettype wire
